// >>> mcu_seq_defs.svh
// Offsets, field positions, reset values and vectors of the sequencer
`ifndef MCU_SEQ_DEFS_SVH
`define MCU_SEQ_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define PCL_OFFSET     12'h000
`define CTRL_OFFSET    12'h004
`define STATUS_OFFSET  12'h008

// ---------------------------------------------------------------
// Control and status fields
// ---------------------------------------------------------------
`define CTRL_CLK_SEL   0
`define CTRL_RUN       1
`define CTRL_RESET     2'h2
`define ST_PC_LSB      0
`define ST_DEPTH_LSB   10
`define ST_FLAG_LSB    16
`define ST_ACC_LSB     24

// ---------------------------------------------------------------
// Status flag positions
// ---------------------------------------------------------------
`define FLAG_C         0
`define FLAG_AC        1
`define FLAG_Z         2
`define FLAG_OV        3

// ---------------------------------------------------------------
// Instruction word fields
// ---------------------------------------------------------------
`define OP_MSB         13
`define OP_LSB         11
`define FUNC_MSB       10
`define FUNC_LSB       7
`define DEST_BIT       6
`define DADDR_MSB      5
`define TARGET_MSB     9

// ---------------------------------------------------------------
// Vectors and sizes
// ---------------------------------------------------------------
`define RESET_VECTOR   10'h000
`define IRQ_VECTOR     10'h004
`define STACK_LEVELS   6

`endif

// >>> mcu_seq_pkg.sv
// Types shared by the program sequencer modules
package mcu_seq_pkg;

  typedef enum logic [2:0] {
    OP_NOP                         = 3'h0,
    OP_UNCONDITIONAL_BRANCH_INSTR  = 3'h1,
    OP_CALL                        = 3'h2,
    OP_SUBROUTINE_EXIT_INSTR       = 3'h3,
    OP_INTERRUPT_EXIT_INSTR        = 3'h4,
    OP_ALU                         = 3'h5,
    OP_SKIP_ZERO                   = 3'h6,
    OP_LOAD_PC_LOW_BYTE            = 3'h7
  } op_t;

  typedef enum logic [3:0] {
    F_ADD = 4'h0, F_ADC = 4'h1, F_SUB = 4'h2, F_SBC = 4'h3,
    F_DAA = 4'h4, F_AND = 4'h5, F_OR  = 4'h6, F_XOR = 4'h7,
    F_CPL = 4'h8, F_RR  = 4'h9, F_RRC = 4'ha, F_RL  = 4'hb,
    F_RLC = 4'hc, F_INC = 4'hd, F_DEC = 4'he, F_MOV = 4'hf
  } alu_func_t;

  typedef enum logic [1:0] {
    PH_T1 = 2'h0, PH_T2 = 2'h1, PH_T3 = 2'h2, PH_T4 = 2'h3
  } phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [3:0]  phase_clk;
    logic [9:0]  pc;
    logic [9:0]  fetch_addr;
    logic [13:0] exec_word;
    logic        exec_valid;
    logic        flush;
    logic [7:0]  acc;
    logic [3:0]  flags;
    logic        irq_pend;
    logic        irq_ack;
    logic [5:0]  data_addr;
    logic        data_wr;
    logic [7:0]  data_wdata;
    logic [1:0]  ctrl;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } seq_state_t;

endpackage

// >>> core_if.sv
// Links the sequencer to its return stack and its ALU
`timescale 1ns/100ps
`default_nettype none
interface core_if;
  import mcu_seq_pkg::*;
  logic       push;
  logic       pop;
  logic [9:0] push_data;
  logic [9:0] top_data;
  logic [2:0] depth;
  logic       full;
  alu_func_t  func;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_result;
  logic [3:0] flags_in;
  logic [3:0] flags_out;
  modport stack_side (input push, pop, push_data,
                      output top_data, depth, full);
  modport alu_side (input func, alu_a, alu_b, flags_in,
                    output alu_result, flags_out);
endinterface
`default_nettype wire

// >>> return_stack.sv
// Hidden return stack for program counter values
`timescale 1ns/100ps
`default_nettype none
`include "mcu_seq_defs.svh"
module return_stack import mcu_seq_pkg::*; #(
  parameter int LEVELS = `STACK_LEVELS
) (
  // Clock and reset
  input wire logic      pclk,
  input wire logic      presetn,
  // Sequencer side
  core_if.stack_side    cif
);
  typedef struct packed {
    logic [LEVELS-1:0][9:0] slot;
    logic [2:0]             wr_ptr;
    logic [2:0]             count;
  } stack_state_t;

  localparam logic [2:0] LAST = 3'(LEVELS - 1);
  localparam logic [2:0] FULL = 3'(LEVELS);

  if (LEVELS < 2 || LEVELS > 7) begin : g_bad_levels
    $error("return_stack: LEVELS must be 2 to 7");
  end

  stack_state_t s_q;
  stack_state_t s_d;
  logic [2:0]   top_idx;

  assign top_idx       = (s_q.wr_ptr == 3'h0) ? LAST : s_q.wr_ptr - 3'h1;
  assign cif.top_data  = s_q.slot[top_idx];
  assign cif.depth     = s_q.count;
  assign cif.full      = (s_q.count == FULL);

  // Circular slots: a push when full overwrites the oldest entry
  always_comb begin
    s_d = s_q;
    if (cif.push) begin
      s_d.slot[s_q.wr_ptr] = cif.push_data;
      s_d.wr_ptr = (s_q.wr_ptr == LAST) ? 3'h0 : s_q.wr_ptr + 3'h1;
      if (s_q.count != FULL) begin
        s_d.count = s_q.count + 3'h1;
      end
    end else if (cif.pop && s_q.count != 3'h0) begin
      s_d.wr_ptr = top_idx;
      s_d.count  = s_q.count - 3'h1;
    end
  end

  // Empty stack after any reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_overflow_keeps_full;
    @(posedge pclk) disable iff (!presetn)
    cif.push && cif.full |=> cif.full && cif.depth == FULL;
  endproperty
  a_overflow_keeps_full: assert property (p_overflow_keeps_full)
    else $error("stack depth changed on overflow push");

  property p_push_pop_depth;
    @(posedge pclk) disable iff (!presetn)
    cif.pop && !cif.push && cif.depth != 3'h0
      |=> cif.depth == $past(cif.depth) - 3'h1 && !cif.full;
  endproperty
  a_push_pop_depth: assert property (p_push_pop_depth)
    else $error("pop did not free one stack level");
endmodule
`default_nettype wire

// >>> alu8.sv
// Eight-bit ALU with status flag generation
`timescale 1ns/100ps
`default_nettype none
`include "mcu_seq_defs.svh"
module alu8 import mcu_seq_pkg::*; (
  // Operands, function and flags
  core_if.alu_side aif
);
  logic       sub;
  logic       cin;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] bsel;
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] adj;
  logic [8:0] dsum;
  logic [7:0] res;
  logic [3:0] fl;

  assign a    = aif.alu_a;
  assign b    = aif.alu_b;
  assign sub  = (aif.func == F_SUB) || (aif.func == F_SBC);
  assign bsel = sub ? ~b : b;
  // Carry flag high means no borrow on subtract
  assign cin  = (aif.func == F_ADC || aif.func == F_SBC) ?
                aif.flags_in[`FLAG_C] : sub;
  assign sum  = {1'b0, a} + {1'b0, bsel} + {8'h00, cin};
  assign half = {1'b0, a[3:0]} + {1'b0, bsel[3:0]} + {4'h0, cin};
  assign adj  = {(a[7:4] > 4'h9 || aif.flags_in[`FLAG_C] ||
                  (a[7:4] == 4'h9 && a[3:0] > 4'h9)) ? 4'h6 : 4'h0,
                 (a[3:0] > 4'h9 || aif.flags_in[`FLAG_AC]) ? 4'h6 : 4'h0};
  assign dsum = {1'b0, a} + {1'b0, adj};

  always_comb begin
    res = b;
    fl  = aif.flags_in;
    unique case (aif.func)
      F_ADD, F_ADC, F_SUB, F_SBC: begin
        res          = sum[7:0];
        fl[`FLAG_C]  = sum[8];
        fl[`FLAG_AC] = half[4];
        fl[`FLAG_OV] = (a[7] == bsel[7]) && (sum[7] != a[7]);
      end
      F_DAA: begin
        res         = dsum[7:0];
        fl[`FLAG_C] = aif.flags_in[`FLAG_C] | dsum[8];
      end
      F_AND: res = a & b;
      F_OR:  res = a | b;
      F_XOR: res = a ^ b;
      F_CPL: res = ~b;
      F_RR:  res = {b[0], b[7:1]};
      F_RRC: begin
        res         = {aif.flags_in[`FLAG_C], b[7:1]};
        fl[`FLAG_C] = b[0];
      end
      F_RL:  res = {b[6:0], b[7]};
      F_RLC: begin
        res         = {b[6:0], aif.flags_in[`FLAG_C]};
        fl[`FLAG_C] = b[7];
      end
      F_INC: res = b + 8'h01;
      F_DEC: res = b - 8'h01;
      F_MOV: res = b;
    endcase
    // Rotates leave the zero flag alone
    if (!(aif.func inside {F_RR, F_RRC, F_RL, F_RLC})) begin
      fl[`FLAG_Z] = (res == 8'h00);
    end
  end

  assign aif.alu_result = res;
  assign aif.flags_out  = fl;
endmodule
`default_nettype wire

// >>> mcu_program_sequencer.sv
// Program sequencer: phases, fetch pipeline, counter, stack, ALU, APB
`timescale 1ns/100ps
`default_nettype none
`include "mcu_seq_defs.svh"
module mcu_program_sequencer import mcu_seq_pkg::*; #(
  parameter int         STACK_LEVELS = `STACK_LEVELS,
  parameter logic [9:0] IRQ_VECTOR   = `IRQ_VECTOR
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Oscillator ticks, one pclk wide
  input  wire logic        fast_internal_oscillator,
  input  wire logic        slow_internal_oscillator,
  // Program memory
  output logic      [9:0]  prog_addr,
  input  wire logic [13:0] prog_rdata,
  // Data memory
  output logic      [5:0]  data_addr,
  input  wire logic [7:0]  data_rdata,
  output logic             data_wr,
  output logic      [7:0]  data_wdata,
  // Interrupt
  input  wire logic        irq_req,
  output logic             irq_ack,
  // Phase indication
  output logic      [3:0]  instruction_phase_clocks
);
  // ---------------------------------------------------------------
  // Elaboration checks and reset image
  // ---------------------------------------------------------------
  if (STACK_LEVELS < 2 || STACK_LEVELS > 7) begin : g_bad_levels
    $error("mcu_program_sequencer: STACK_LEVELS must be 2 to 7");
  end

  // Fetch of the vector is already in flight while reset is held
  localparam seq_state_t SEQ_RESET = '{
    phase: PH_T1, phase_clk: 4'h1, pc: 10'(`RESET_VECTOR + 10'h001),
    fetch_addr: `RESET_VECTOR, exec_word: 14'h0000, exec_valid: 1'b0,
    flush: 1'b0, acc: 8'h00, flags: 4'h0, irq_pend: 1'b0,
    irq_ack: 1'b0, data_addr: 6'h00, data_wr: 1'b0,
    data_wdata: 8'h00, ctrl: `CTRL_RESET, pready: 1'b0,
    prdata: 32'h0000_0000, pslverr: 1'b0};

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  core_if cif ();

  return_stack #(
    .LEVELS  (STACK_LEVELS)
  ) u_stack (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif.stack_side)
  );

  alu8 u_alu (
    .aif     (cif.alu_side)
  );

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  seq_state_t s_q;
  seq_state_t s_d;
  logic       tick;
  logic       end_cycle;
  op_t        op;
  logic       live;
  logic       apb_access;
  logic       apb_write;
  logic       hit;
  logic [31:0] rd_word;
  logic       redirect;
  logic [9:0] target;

  // Slow or fast oscillator paces the phases
  assign tick = s_q.ctrl[`CTRL_CLK_SEL] ? slow_internal_oscillator
                                        : fast_internal_oscillator;
  assign end_cycle  = tick && s_q.ctrl[`CTRL_RUN] && s_q.phase == PH_T4;
  assign op         = op_t'(s_q.exec_word[`OP_MSB:`OP_LSB]);
  assign live       = s_q.exec_valid && !s_q.flush;
  assign apb_access = psel && penable && !s_q.pready;
  assign apb_write  = psel && penable && s_q.pready && pwrite;

  // Accumulator against memory operand
  assign cif.func      = alu_func_t'(s_q.exec_word[`FUNC_MSB:`FUNC_LSB]);
  assign cif.alu_a     = s_q.acc;
  assign cif.alu_b     = data_rdata;
  assign cif.flags_in  = s_q.flags;
  assign cif.push_data = s_q.fetch_addr;

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    hit     = 1'b1;
    unique case (paddr)
      `PCL_OFFSET: rd_word[7:0] = s_q.pc[7:0];
      `CTRL_OFFSET: rd_word[1:0] = s_q.ctrl;
      `STATUS_OFFSET: begin
        rd_word[`ST_PC_LSB +: 10]   = s_q.pc;
        // Stack pointer stays hidden from software
        rd_word[`ST_FLAG_LSB +: 4]  = s_q.flags;
        rd_word[`ST_ACC_LSB +: 8]   = s_q.acc;
      end
      default: hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.irq_ack  = 1'b0;
    s_d.data_wr  = 1'b0;
    s_d.pready   = 1'b0;
    s_d.pslverr  = 1'b0;
    cif.push     = 1'b0;
    cif.pop      = 1'b0;
    redirect     = 1'b0;
    target       = s_q.pc;

    // Request latched until it can be acknowledged
    if (irq_req) begin
      s_d.irq_pend = 1'b1;
    end

    if (tick && s_q.ctrl[`CTRL_RUN]) begin
      s_d.phase     = phase_t'(2'(s_q.phase + 2'h1));
      s_d.phase_clk = {s_q.phase_clk[2:0], s_q.phase_clk[3]};
    end

    if (end_cycle) begin
      if (live) begin
        unique case (op)
          OP_NOP: begin
          end
          OP_UNCONDITIONAL_BRANCH_INSTR: begin
            redirect = 1'b1;
            target   = s_q.exec_word[`TARGET_MSB:0];
          end
          OP_CALL: begin
            cif.push = 1'b1;
            redirect = 1'b1;
            target   = s_q.exec_word[`TARGET_MSB:0];
          end
          OP_SUBROUTINE_EXIT_INSTR, OP_INTERRUPT_EXIT_INSTR: begin
            cif.pop  = 1'b1;
            redirect = 1'b1;
            target   = cif.top_data;
          end
          OP_ALU: begin
            s_d.flags = cif.flags_out;
            if (s_q.exec_word[`DEST_BIT]) begin
              s_d.data_wr    = 1'b1;
              s_d.data_wdata = cif.alu_result;
            end else begin
              s_d.acc = cif.alu_result;
            end
          end
          OP_SKIP_ZERO: begin
            // Drop the prefetched word, fetch the one after it
            if (s_q.flags[`FLAG_Z]) begin
              redirect = 1'b1;
              target   = s_q.pc;
            end
          end
          OP_LOAD_PC_LOW_BYTE: begin
            redirect = 1'b1;
            target   = {s_q.fetch_addr[9:8], s_q.acc};
          end
        endcase
      end

      // Software write already placed the new counter value
      if (s_q.flush) begin
        redirect = 1'b1;
        target   = s_q.pc;
      end

      // Acknowledge waits for a free stack level
      if (!redirect && s_q.irq_pend && !cif.full) begin
        cif.push     = 1'b1;
        redirect     = 1'b1;
        target       = IRQ_VECTOR;
        s_d.irq_pend = irq_req;
        s_d.irq_ack  = 1'b1;
      end

      if (redirect) begin
        s_d.fetch_addr = target;
        s_d.pc         = 10'(target + 10'h001);
        s_d.exec_valid = 1'b0;
      end else begin
        s_d.fetch_addr = s_q.pc;
        s_d.pc         = 10'(s_q.pc + 10'h001);
        s_d.exec_word  = prog_rdata;
        s_d.exec_valid = 1'b1;
        s_d.data_addr  = prog_rdata[`DADDR_MSB:0];
      end
      s_d.flush = 1'b0;
    end

    // APB: one wait state, then the answer with pready high
    if (apb_access) begin
      s_d.pready  = 1'b1;
      s_d.prdata  = pwrite ? 32'h0000_0000 : rd_word;
      s_d.pslverr = !hit;
    end
    if (apb_write && paddr == `PCL_OFFSET) begin
      s_d.pc[7:0] = pwdata[7:0];
      s_d.flush   = 1'b1;
    end
    if (apb_write && paddr == `CTRL_OFFSET) begin
      s_d.ctrl = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= SEQ_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata                   = s_q.prdata;
  assign pready                   = s_q.pready;
  assign pslverr                  = s_q.pslverr;
  assign prog_addr                = s_q.fetch_addr;
  assign data_addr                = s_q.data_addr;
  assign data_wr                  = s_q.data_wr;
  assign data_wdata               = s_q.data_wdata;
  assign irq_ack                  = s_q.irq_ack;
  assign instruction_phase_clocks = s_q.phase_clk;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_phase_wrap;
    tick && s_q.ctrl[`CTRL_RUN] && instruction_phase_clocks[3]
      |=> instruction_phase_clocks == 4'h1;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap)
    else $error("phase did not wrap to the first phase");

  property p_osc_select;
    s_q.ctrl[`CTRL_CLK_SEL] && !slow_internal_oscillator
      |=> $stable(instruction_phase_clocks);
  endproperty
  a_osc_select: assert property (p_osc_select)
    else $error("phase moved without a slow oscillator tick");

  property p_fetch_incr;
    end_cycle && !redirect
      |=> prog_addr == $past(s_q.pc) && s_q.exec_valid;
  endproperty
  a_fetch_incr: assert property (p_fetch_incr)
    else $error("sequential fetch address wrong");

  property p_branch_dummy;
    end_cycle && live && op == OP_UNCONDITIONAL_BRANCH_INSTR
      |=> prog_addr == $past(s_q.exec_word[9:0]) && !s_q.exec_valid;
  endproperty
  a_branch_dummy: assert property (p_branch_dummy)
    else $error("branch did not redirect with a dummy cycle");

  property p_skip_taken;
    end_cycle && live && op == OP_SKIP_ZERO && s_q.flags[`FLAG_Z]
      |=> !s_q.exec_valid && prog_addr == $past(s_q.pc);
  endproperty
  a_skip_taken: assert property (p_skip_taken)
    else $error("taken skip did not discard the next word");

  property p_pcl_write;
    apb_write && paddr == `PCL_OFFSET && !end_cycle
      |=> s_q.pc[7:0] == $past(pwdata[7:0])
          && s_q.pc[9:8] == $past(s_q.pc[9:8]) && s_q.flush;
  endproperty
  a_pcl_write: assert property (p_pcl_write)
    else $error("low byte write altered the page or lost the flush");

  property p_irq_held;
    s_q.irq_pend && cif.full |=> !irq_ack;
  endproperty
  a_irq_held: assert property (p_irq_held)
    else $error("interrupt acknowledged with stack full");

  property p_irq_vector;
    irq_ack |-> prog_addr == IRQ_VECTOR && !s_q.exec_valid;
  endproperty
  a_irq_vector: assert property (p_irq_vector)
    else $error("interrupt acknowledge without vector fetch");

  property p_alu_acc;
    end_cycle && live && op == OP_ALU && !s_q.exec_word[`DEST_BIT]
      |=> s_q.acc == $past(cif.alu_result) && !data_wr;
  endproperty
  a_alu_acc: assert property (p_alu_acc)
    else $error("ALU result not written to the accumulator");

  property p_cover_call;
    end_cycle && live && op == OP_CALL;
  endproperty
  c_cover_call: cover property (p_cover_call);

  property p_cover_irq_after_full;
    cif.full && s_q.irq_pend ##[1:200] irq_ack;
  endproperty
  c_cover_irq_after_full: cover property (p_cover_irq_after_full);

  property p_cover_skip;
    end_cycle && live && op == OP_SKIP_ZERO && s_q.flags[`FLAG_Z];
  endproperty
  c_cover_skip: cover property (p_cover_skip);

  property p_cover_pcl;
    apb_write && paddr == `PCL_OFFSET;
  endproperty
  c_cover_pcl: cover property (p_cover_pcl);
endmodule
`default_nettype wire

// >>> mcu_program_sequencer_tb.sv
// Self-checking bench for the program sequencer
`timescale 1ns/100ps
`default_nettype none
module mcu_program_sequencer_tb;
  import mcu_seq_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        fast_internal_oscillator, slow_internal_oscillator;
  logic        data_wr, irq_req, irq_ack, ret_mode, tick_en, alu_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0]  prog_addr;
  logic [13:0] prog_rdata;
  logic [5:0]  data_addr;
  logic [7:0]  data_rdata, data_wdata, v;
  logic [3:0]  instruction_phase_clocks, ph;
  logic [32:0] exp_q[$], msk_q[$];
  int          err_count, total_checks, acks, wrs;

  mcu_program_sequencer uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .fast_internal_oscillator,
    .slow_internal_oscillator, .prog_addr, .prog_rdata, .data_addr,
    .data_rdata, .data_wr, .data_wdata, .irq_req, .irq_ack,
    .instruction_phase_clocks);

  // Whole memory: call into page two, return, or increment memory word 5
  assign prog_rdata = alu_mode ? 14'h2ec5 : ret_mode ? 14'h1800 : 14'h12f0;

  always #4 pclk = ~pclk;

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Called just after a rising edge; notes the masked expectation
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e,
                     input logic [32:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // --------------------------------------------------------------
  // Output watcher
  // --------------------------------------------------------------
  always @(posedge pclk) begin
    fast_internal_oscillator <= tick_en & 1'($urandom_range(1));
    if (!alu_mode)
      data_rdata <= 8'($urandom);
    if (presetn) begin
      check({29'h0, instruction_phase_clocks &
             (instruction_phase_clocks - 4'h1)}, 33'h0);
      if (irq_ack === 1'b1)
        acks++;
      if (data_wr === 1'b1) begin
        wrs++;
        check({27'h0, data_addr}, 33'h5);
        check({25'h0, data_wdata}, {25'h0, data_rdata + 8'h1});
      end
      if (pready === 1'b1) begin
        check({pslverr, prdata} & msk_q[0], exp_q[0]);
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end

  initial begin
    #100000;
    check(33'h1, 33'h0);
    print_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, irq_req, ret_mode, tick_en} = '0;
    {alu_mode, pclk} = '0;
    {fast_internal_oscillator, slow_internal_oscillator} = '0;
    paddr = '0;
    pwdata = '0;
    data_rdata = '0;
    {err_count, total_checks, acks, wrs} = '0;
    void'($urandom(32'h4dfaf862));
    repeat (12) @(posedge pclk);
    check({29'h0, instruction_phase_clocks}, 33'h1);
    check({23'h0, prog_addr}, 33'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h004, 0, 33'h2, 33'h1ffffffff);
    apb(0, 12'h008, 0, 33'h1, 33'h1_00001fff);
    apb(0, 12'h000, 0, 33'h1, 33'h1_000000ff);
    apb(1, 12'h00c, 0, 33'h1_00000000, 33'h1_00000000);
    apb(0, 12'h00c, 0, 33'h1_00000000, 33'h1ffffffff);
    tick_en <= 1'b1;
    repeat (300) @(posedge pclk);
    irq_req <= 1'b1;
    @(posedge pclk);
    irq_req <= 1'b0;
    repeat (100) @(posedge pclk);
    check({32'h0, acks != 0}, 33'h0);
    apb(1, 12'h004, 0, 33'h0, 33'h1_00000000);
    apb(0, 12'h008, 0, 33'h0200, 33'h1_00001f00);
    v = 8'($urandom);
    apb(1, 12'h000, {24'h0, v}, 33'h0, 33'h1_00000000);
    apb(0, 12'h008, 0, {25'h2, v}, 33'h1_000003ff);
    apb(0, 12'h000, 0, {25'h0, v}, 33'h1_000000ff);
    apb(1, 12'h004, 32'h3, 33'h0, 33'h1_00000000);
    ph = instruction_phase_clocks;
    repeat (40) @(posedge pclk);
    check({29'h0, instruction_phase_clocks}, {29'h0, ph});
    ret_mode <= 1'b1;
    apb(1, 12'h004, 32'h2, 33'h0, 33'h1_00000000);
    repeat (300) @(posedge pclk);
    check({32'h0, acks != 0}, 33'h1);
    alu_mode <= 1'b1;
    repeat (200) @(posedge pclk);
    check({32'h0, wrs != 0}, 33'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({23'h0, prog_addr}, 33'h0);
    check({29'h0, instruction_phase_clocks}, 33'h1);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h008, 0, 33'h1, 33'h1_000003ff);
    print_verdict();
  end
endmodule
`default_nettype wire
